// File: design/lcd_src_pkg.sv
package lcd_src_pkg;

  // ----------------------------------------------------------------
  // Column geometry and latch counts
  // ----------------------------------------------------------------
  localparam int unsigned COLUMNS = 120;
  localparam int unsigned COLOURS = 3;
  localparam logic [6:0] FIRST_COL = 7'h00;
  localparam logic [6:0] LAST_COL = 7'h77;
  // Right-shift jump over the invalid band in 324 mode (column 54 -> 67)
  localparam logic [6:0] SKIP_ENTRY_R = 7'h35;
  localparam logic [6:0] SKIP_EXIT_R = 7'h42;
  // Invalid band, zero-based (columns 54 to 65)
  localparam logic [6:0] BAND_FIRST = 7'h36;
  localparam logic [6:0] BAND_LAST = 7'h41;
  localparam logic [6:0] LATCHES_360 = 7'h78;
  localparam logic [6:0] LATCHES_324 = 7'h6c;
  localparam logic [6:0] CARRY_AT_360 = 7'h77;
  localparam logic [6:0] CARRY_AT_324 = 7'h6b;
  localparam logic [1:0] CARRY_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int unsigned MODE_COLS_BIT = 0;
  localparam int unsigned MODE_FMT_BIT = 1;
  localparam int unsigned MODE_DIR_BIT = 2;
  localparam logic [2:0] MODE_RESET = 3'h5;
  localparam int unsigned STAT_ACTIVE_BIT = 8;
  localparam int unsigned STAT_PS_BIT = 9;
  localparam int unsigned STAT_GAP_BIT = 10;
  localparam int unsigned STAT_FMT_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Gamma decoding
  // ----------------------------------------------------------------
  localparam logic [3:0] TAP_OFFSET = 4'h2;
  localparam logic [3:0] TAP_NINE = 4'h9;
  localparam logic [3:0] TAP_TEN = 4'ha;
  localparam logic [5:0] CODE_BLACK = 6'h00;
  localparam logic [5:0] CODE_TAP9 = 6'h3e;
  localparam logic [5:0] CODE_TAP10 = 6'h3f;
  localparam logic [2:0] FRAC_TOP = 3'h7;
  localparam logic [5:0] MSB_ONLY = 6'h20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } pixel_s;

  // Level = tap + (tap-1 minus tap) * frac / (sevenths ? 7 : 8)
  typedef struct packed {
    logic [3:0] tap;
    logic [2:0] frac;
    logic sevenths;
  } gamma_s;

  typedef struct packed {
    logic hiz;
    logic level;
    gamma_s code;
  } column_drive_s;

  localparam column_drive_s COL_RESET = '{hiz: 1'b1, level: 1'b0, code: '0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } shift_state_e;

endpackage

// File: design/gamma_tap_decoder.sv
`timescale 1ns/100ps
module gamma_tap_decoder
  import lcd_src_pkg::*;
(
  // Pixel code
  input wire logic [5:0] code,
  // Reference tap selection
  output lcd_src_pkg::gamma_s sel
);

  // ----------------------------------------------------------------
  // Code to tap and weight
  // ----------------------------------------------------------------
  // Tap and weight per 6-bit code
  always_comb
  begin
    sel = '0;
    if (code == CODE_BLACK)
    begin
      sel.tap = 4'h0;
    end
    else if (code == CODE_TAP10)
    begin
      sel.tap = TAP_TEN;
    end
    else if (code == CODE_TAP9)
    begin
      sel.tap = TAP_NINE;
    end
    else
    begin
      sel.tap = {1'b0, code[5:3]} + TAP_OFFSET;
      sel.frac = FRAC_TOP - code[2:0];
      sel.sevenths = (code[5:3] == 3'h0);
    end
  end

endmodule

// File: design/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic ready_r;
  logic push;
  logic pop;

  // Handshakes
  assign push = in_valid && ready_r;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // Occupancy after this edge
  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = count_r + CW'(1);
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - CW'(1);
    end
  end

  // Pointers, count and registered ready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      ready_r <= (count_nxt != CW'(DEPTH));
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
      end
    end
  end

  // Storage
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule

// File: design/lcd_source_driver_latch_ctrl.sv
// Functional notes
// - 324 mode skips columns 55 to 66
// - Single-bit mode keeps only each MSB
// - Invert complements pixel before latching
// - Format change: one cycle high impedance
// - Latching begins cycle after start sampled
// - Carry one cycle before final latch
// - Carry pulse lasts two cycles
// - Direction low: start left, carry right
// - Code 00 tap 0; 01-06 sevenths
// - Taps 2-8 exact, eighths between
// - 38-3D eighths, 3E tap 9, 3F tap 10
// - Power-save: outputs high-Z, amplifiers off
// - Load strobe transfers line to outputs
// - Direction high fills 1 to 120
// - Format high single-bit, converters off
`timescale 1ns/100ps
module lcd_source_driver_latch_ctrl
  import lcd_src_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pixel stream
  input wire logic [5:0] red_pixel_in,
  input wire logic [5:0] green_pixel_in,
  input wire logic [5:0] blue_pixel_in,
  input wire logic pixel_valid,
  output logic pixel_ready,
  // Strobes
  input wire logic load_strobe,
  input wire logic data_invert,
  input wire logic power_save,
  // Start and carry pins
  input wire logic left_start_carry_in,
  output logic left_start_carry_out,
  output logic left_start_carry_oe_n,
  input wire logic right_start_carry_in,
  output logic right_start_carry_out,
  output logic right_start_carry_oe_n,
  // Column drive
  output lcd_src_pkg::column_drive_s [COLUMNS-1:0] red_column_out,
  output lcd_src_pkg::column_drive_s [COLUMNS-1:0] green_column_out,
  output lcd_src_pkg::column_drive_s [COLUMNS-1:0] blue_column_out,
  output logic amp_enable,
  output logic dac_enable
);

  import lcd_src_pkg::*;

  logic [2:0] mode_r;
  logic awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, status_word;
  logic column_count_select, input_format_select, shift_direction_select;
  logic fmt_applied_r, gap_r, start_prev_r, start_pin, start_evt, load_r;
  logic amp_r, dac_r, left_out_r, left_oe_n_r, right_out_r, right_oe_n_r;
  shift_state_e state_r;
  logic [6:0] pos_r, pos_nxt, latch_cnt_r, latch_cnt_nxt, total, carry_at;
  logic [1:0] carry_cnt_r, carry_cnt_nxt;
  pixel_s buf_in, buf_out;
  logic buf_valid, pop;
  logic [5:0] line_r [COLOURS][COLUMNS];
  gamma_s dec_w [COLOURS][COLUMNS];
  column_drive_s [COLUMNS-1:0] col_r [COLOURS];

  assign column_count_select = mode_r[MODE_COLS_BIT];
  assign input_format_select = mode_r[MODE_FMT_BIT];
  assign shift_direction_select = mode_r[MODE_DIR_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign awready = awready_r;
  assign wready = awready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // Write channel: address and data taken together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (awready_r)
    begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr == ADDR_MODE || awaddr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_r)
    begin
      bvalid_r <= !bready;
    end
    else if (awvalid && wvalid)
    begin
      awready_r <= 1'b1;
    end
  end

  // Mode register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= MODE_RESET;
    end
    else if (awready_r && awaddr == ADDR_MODE && wstrb[0])
    begin
      mode_r <= wdata[2:0];
    end
  end

  // Status word
  always_comb
  begin
    status_word = '0;
    status_word[6:0] = latch_cnt_r;
    status_word[STAT_ACTIVE_BIT] = (state_r == ST_SHIFT);
    status_word[STAT_PS_BIT] = !amp_r;
    status_word[STAT_GAP_BIT] = gap_r;
    status_word[STAT_FMT_BIT] = fmt_applied_r;
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      if (araddr == ADDR_MODE)
      begin
        rdata_r <= {29'h0, mode_r};
      end
      else if (araddr == ADDR_STATUS)
      begin
        rdata_r <= status_word;
      end
      else
      begin
        rresp_r <= RESP_SLVERR;
      end
    end
    else if (rvalid_r)
    begin
      rvalid_r <= !rready;
    end
    else if (arvalid)
    begin
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Input path and format switching
  // ----------------------------------------------------------------
  // Word conditioning ahead of the buffer
  always_comb
  begin
    buf_in = {red_pixel_in, green_pixel_in, blue_pixel_in} ^ {18{data_invert}};
    if (fmt_applied_r)
    begin
      buf_in.red = buf_in.red & MSB_ONLY;
      buf_in.green = buf_in.green & MSB_ONLY;
      buf_in.blue = buf_in.blue & MSB_ONLY;
    end
  end

  two_entry_buffer #(.WIDTH(18), .DEPTH(2)) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(buf_in),
    .in_valid(pixel_valid),
    .in_ready(pixel_ready),
    .out_data(buf_out),
    .out_valid(buf_valid),
    .out_ready(state_r == ST_SHIFT)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fmt_applied_r <= 1'b0;
      gap_r <= 1'b0;
    end
    else if (gap_r)
    begin
      gap_r <= 1'b0;
      fmt_applied_r <= input_format_select;
    end
    else
    begin
      gap_r <= (input_format_select != fmt_applied_r);
    end
  end

  // ----------------------------------------------------------------
  // Shift sequencing
  // ----------------------------------------------------------------
  // start pin by direction
  assign start_pin = shift_direction_select ? right_start_carry_in : left_start_carry_in;
  assign start_evt = start_pin && !start_prev_r;
  assign pop = (state_r == ST_SHIFT) && buf_valid;
  assign total = column_count_select ? LATCHES_360 : LATCHES_324;
  assign carry_at = column_count_select ? CARRY_AT_360 : CARRY_AT_324;
  assign latch_cnt_nxt = latch_cnt_r + 7'h01;

  // Next column, direction and band skip
  always_comb
  begin
    pos_nxt = shift_direction_select ? pos_r + 7'h01 : pos_r - 7'h01;
    if (!column_count_select && shift_direction_select && pos_r == SKIP_ENTRY_R)
    begin
      pos_nxt = SKIP_EXIT_R;
    end
    else if (!column_count_select && !shift_direction_select && pos_r == SKIP_EXIT_R)
    begin
      pos_nxt = SKIP_ENTRY_R;
    end
  end

  // Start edge memory
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_prev_r <= 1'b0;
    end
    else
    begin
      start_prev_r <= start_pin;
    end
  end

  // Shift state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      pos_r <= FIRST_COL;
      latch_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_evt)
          begin
            state_r <= ST_SHIFT;
            pos_r <= shift_direction_select ? FIRST_COL : LAST_COL;
            latch_cnt_r <= '0;
          end
        end
        ST_SHIFT:
        begin
          if (pop)
          begin
            latch_cnt_r <= latch_cnt_nxt;
            pos_r <= pos_nxt;
            if (latch_cnt_nxt == total)
            begin
              state_r <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Line latch
  always_ff @(posedge aclk)
  begin
    if (pop)
    begin
      line_r[0][pos_r] <= buf_out.red;
      line_r[1][pos_r] <= buf_out.green;
      line_r[2][pos_r] <= buf_out.blue;
    end
  end

  // ----------------------------------------------------------------
  // Carry out
  // ----------------------------------------------------------------
  // carry ahead of final latch
  always_comb
  begin
    carry_cnt_nxt = (carry_cnt_r != 2'h0) ? carry_cnt_r - 2'h1 : 2'h0;
    if (pop && latch_cnt_nxt == carry_at)
    begin
      carry_cnt_nxt = CARRY_CYCLES;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      carry_cnt_r <= 2'h0;
      left_out_r <= 1'b0;
      right_out_r <= 1'b0;
      left_oe_n_r <= 1'b1;
      right_oe_n_r <= 1'b1;
    end
    else
    begin
      carry_cnt_r <= carry_cnt_nxt;
      left_out_r <= shift_direction_select && (carry_cnt_nxt != 2'h0);
      right_out_r <= !shift_direction_select && (carry_cnt_nxt != 2'h0);
      left_oe_n_r <= !shift_direction_select;
      right_oe_n_r <= shift_direction_select;
    end
  end

  assign left_start_carry_out = left_out_r;
  assign left_start_carry_oe_n = left_oe_n_r;
  assign right_start_carry_out = right_out_r;
  assign right_start_carry_oe_n = right_oe_n_r;

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Load sample, amplifier and converter enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_r <= 1'b0;
      amp_r <= 1'b0;
      dac_r <= 1'b0;
    end
    else
    begin
      load_r <= load_strobe;
      amp_r <= !power_save;
      dac_r <= !power_save && !fmt_applied_r;
    end
  end

  assign amp_enable = amp_r;
  assign dac_enable = dac_r;

  // Per colour and column decode and drive
  for (genvar k = 0; k < COLOURS; k++)
  begin : g_colour
    for (genvar c = 0; c < COLUMNS; c++)
    begin : g_col
      gamma_tap_decoder u_dec (
        .code(line_r[k][c]),
        .sel(dec_w[k][c])
      );
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          col_r[k][c] <= COL_RESET;
        end
        else
        begin
          col_r[k][c].hiz <= power_save || gap_r || (!column_count_select
            && 7'(c) >= BAND_FIRST && 7'(c) <= BAND_LAST);
          if (load_r)
          begin
            col_r[k][c].level <= fmt_applied_r && line_r[k][c][5];
            col_r[k][c].code <= fmt_applied_r ? '0 : dec_w[k][c];
          end
        end
      end
    end
  end

  assign red_column_out = col_r[0];
  assign green_column_out = col_r[1];
  assign blue_column_out = col_r[2];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_shift;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == ST_IDLE && start_evt) |=> (state_r == ST_SHIFT) && latch_cnt_r == 7'h00;
  endproperty
  a_start_shift: assert property (p_start_shift) else $error("start not taken");

  property p_fill_order;
    @(posedge aclk) disable iff (!aresetn)
    (state_r == ST_IDLE && start_evt) |=>
      pos_r == ($past(shift_direction_select) ? FIRST_COL : LAST_COL);
  endproperty
  a_fill_order: assert property (p_fill_order) else $error("wrong first column");

  property p_skip_band;
    @(posedge aclk) disable iff (!aresetn)
    (pop && !column_count_select && shift_direction_select && pos_r == SKIP_ENTRY_R)
      |=> pos_r == SKIP_EXIT_R;
  endproperty
  a_skip_band: assert property (p_skip_band) else $error("band not skipped");

  property p_invert;
    @(posedge aclk) disable iff (!aresetn)
    (data_invert && !fmt_applied_r) |-> buf_in.red == ~red_pixel_in;
  endproperty
  a_invert: assert property (p_invert) else $error("pixel not inverted");

  property p_msb_only;
    @(posedge aclk) disable iff (!aresetn)
    fmt_applied_r |-> buf_in.green[4:0] == 5'h00 && buf_in.blue[4:0] == 5'h00;
  endproperty
  a_msb_only: assert property (p_msb_only) else $error("low bits kept");

  property p_format_gap;
    @(posedge aclk) disable iff (!aresetn)
    (!gap_r && input_format_select != fmt_applied_r) |=> gap_r ##1 !gap_r && col_r[0][0].hiz;
  endproperty
  a_format_gap: assert property (p_format_gap) else $error("format gap wrong");

  property p_carry_len;
    @(posedge aclk) disable iff (!aresetn)
    $rose(carry_cnt_r != 2'h0) |-> (carry_cnt_r != 2'h0)[*2] ##1 (carry_cnt_r == 2'h0);
  endproperty
  a_carry_len: assert property (p_carry_len) else $error("carry not two cycles");

  property p_carry_at;
    @(posedge aclk) disable iff (!aresetn)
    (pop && latch_cnt_nxt == carry_at) |=> carry_cnt_r == CARRY_CYCLES
      && latch_cnt_r == carry_at && (left_start_carry_out || right_start_carry_out);
  endproperty
  a_carry_at: assert property (p_carry_at) else $error("carry mistimed");

  property p_stop;
    @(posedge aclk) disable iff (!aresetn)
    (pop && latch_cnt_nxt == total) |=> state_r == ST_IDLE ##1 !pop;
  endproperty
  a_stop: assert property (p_stop) else $error("shifting not stopped");

  property p_power_save;
    @(posedge aclk) disable iff (!aresetn)
    power_save |=> col_r[1][0].hiz && col_r[2][119].hiz && !amp_enable;
  endproperty
  a_power_save: assert property (p_power_save) else $error("power save ignored");

endmodule

// File: verif/timing_ctrl_model.sv
`timescale 1ns/100ps
module timing_ctrl_model (
  // Bench control
  input wire logic aclk,
  input wire logic go,
  input wire logic dir,
  input wire logic [6:0] words,
  input wire lcd_src_pkg::pixel_s word,
  // Pixel stream
  output lcd_src_pkg::pixel_s pix,
  output logic pixel_valid,
  input wire logic pixel_ready,
  // Start and carry pins
  output logic left_start,
  output logic right_start,
  input wire logic left_carry,
  input wire logic right_carry,
  // Carry observation
  output logic [7:0] carry_at,
  output logic [1:0] carry_len,
  output logic [3:0] starts
);
  import lcd_src_pkg::*;
  logic [6:0] left_r;
  logic [7:0] cnt_r;
  logic car_d;
  logic car;

  assign car = dir ? left_carry : right_carry;

  // Idle levels at time zero
  initial
  begin
    {pixel_valid, left_start, right_start, car_d, carry_len, starts} = '0;
    {pix, left_r, cnt_r, carry_at} = '0;
  end

  // Start pulse, word stream and carry watch
  always @(posedge aclk)
  begin
    left_start <= 1'b0;
    right_start <= 1'b0;
    cnt_r <= cnt_r + 8'h1;
    car_d <= car;
    if (pixel_valid && pixel_ready)
    begin
      left_r <= left_r - 7'h1;
      if (left_r == 7'h1)
      begin
        pixel_valid <= 1'b0;
        pix <= ~pix;
      end
    end
    if (go)
    begin
      right_start <= dir;
      left_start <= !dir;
      pixel_valid <= 1'b1;
      pix <= word;
      left_r <= words;
      cnt_r <= 8'h0;
      carry_len <= 2'h0;
    end
    if (car && !car_d)
    begin
      carry_at <= cnt_r;
      starts <= starts + 4'h1;
    end
    if (car)
      carry_len <= carry_len + 2'h1;
  end
endmodule

// File: verif/lcd_source_driver_latch_ctrl_test.sv
`timescale 1ns/100ps
module lcd_source_driver_latch_ctrl_test;
  import lcd_src_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, pixel_valid, pixel_ready, load_strobe, data_invert;
  logic power_save, go, dir, ls_in, rs_in, ls_out, rs_out, ls_oe_n, rs_oe_n;
  logic amp_enable, dac_enable;
  logic [3:0] awaddr, araddr, wstrb, starts;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, carry_len, rsp;
  logic [6:0] words;
  logic [7:0] carry_at;
  pixel_s word, pix;
  column_drive_s [COLUMNS-1:0] red_col, green_col, blue_col;
  int mismatches, comparisons, hz;

  lcd_source_driver_latch_ctrl u_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .red_pixel_in(pix.red), .green_pixel_in(pix.green),
    .blue_pixel_in(pix.blue), .pixel_valid, .pixel_ready, .load_strobe, .data_invert,
    .power_save, .left_start_carry_in(ls_in), .left_start_carry_out(ls_out),
    .left_start_carry_oe_n(ls_oe_n), .right_start_carry_in(rs_in),
    .right_start_carry_out(rs_out), .right_start_carry_oe_n(rs_oe_n),
    .red_column_out(red_col), .green_column_out(green_col),
    .blue_column_out(blue_col), .amp_enable, .dac_enable
  );

  timing_ctrl_model u_ctrl (
    .aclk, .go, .dir, .words, .word, .pix, .pixel_valid, .pixel_ready,
    .left_start(ls_in), .right_start(rs_in), .left_carry(ls_out),
    .right_carry(rs_out), .carry_at, .carry_len, .starts
  );

  // Clock source
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout;
    mismatches++;
    complete_run();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    for (int n = 0; n < 50 && !b; n++)
    begin
      @(negedge aclk);
      aw = awready;
      w = wready;
      b = bvalid;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    if (!b)
      timeout();
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    for (int n = 0; n < 50 && !v; n++)
    begin
      @(negedge aclk);
      ar = arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
    end
    if (!v)
      timeout();
  endtask

  // One line of pixels, carry checks, then a load
  task automatic run_line(input logic d, input pixel_s w, input logic [7:0] n_lat);
    logic [3:0] s0;
    s0 = starts;
    dir <= d;
    word <= w;
    words <= n_lat[6:0];
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (int n = 0; n < 300 && starts == s0; n++)
      @(posedge aclk);
    if (starts == s0)
      timeout();
    cyc(4);
    check(carry_at, n_lat);
    check(carry_len, 2'h2);
    check(starts, s0 + 4'h1);
    check(d ? {rs_oe_n, ls_oe_n} : {ls_oe_n, rs_oe_n}, 2'b10);
    load_strobe <= 1'b1;
    cyc(2);
    load_strobe <= 1'b0;
    cyc(4);
  endtask

  task automatic col_chk(input int i, input logic [21:0] e);
    check({red_col[i].hiz, red_col[i].code.tap, red_col[i].code.frac,
      green_col[i].code.tap, green_col[i].code.frac,
      blue_col[i].code.tap, blue_col[i].code.frac}, e);
  endtask

  // ----------
  // Main sequence
  // ----------
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, load_strobe, data_invert} = '0;
    {power_save, go, dir, awaddr, araddr, wdata, words, word, hz} = '0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    axi_read(ADDR_MODE, rd, rsp);
    check(rd[2:0], MODE_RESET);
    axi_read(4'hc, rd, rsp);
    check(rsp, RESP_SLVERR);
    check(rd, 32'h0);
    axi_write(4'h8, 32'h0);
    check(bresp, RESP_SLVERR);
    $display("test registers done");
    run_line(1'b1, '{red: 6'h01, green: 6'h08, blue: 6'h3f}, 8'h78);
    col_chk(0, {1'b0, 4'h2, 3'h6, 4'h3, 3'h7, 4'ha, 3'h0});
    col_chk(119, {1'b0, 4'h2, 3'h6, 4'h3, 3'h7, 4'ha, 3'h0});
    check(red_col[0].code.sevenths, 1'b1);
    check(dac_enable, 1'b1);
    axi_read(ADDR_STATUS, rd, rsp);
    check(rd[11:0], 12'h078);
    $display("test gray right done");
    axi_write(ADDR_MODE, 32'h1);
    data_invert <= 1'b1;
    run_line(1'b0, '{red: 6'h01, green: 6'h08, blue: 6'h3f}, 8'h78);
    data_invert <= 1'b0;
    col_chk(0, {1'b0, 4'h9, 3'h0, 4'h8, 3'h0, 4'h0, 3'h0});
    col_chk(119, {1'b0, 4'h9, 3'h0, 4'h8, 3'h0, 4'h0, 3'h0});
    $display("test inverted left done");
    axi_write(ADDR_MODE, 32'h4);
    run_line(1'b1, '{red: 6'h38, green: 6'h10, blue: 6'h07}, 8'h6c);
    col_chk(53, {1'b0, 4'h9, 3'h7, 4'h4, 3'h7, 4'h2, 3'h0});
    col_chk(66, {1'b0, 4'h9, 3'h7, 4'h4, 3'h7, 4'h2, 3'h0});
    col_chk(54, {1'b1, 4'h9, 3'h0, 4'h8, 3'h0, 4'h0, 3'h0});
    col_chk(119, {1'b0, 4'h9, 3'h7, 4'h4, 3'h7, 4'h2, 3'h0});
    $display("test short line done");
    axi_write(ADDR_MODE, 32'h7);
    repeat (8)
    begin
      @(negedge aclk);
      hz += red_col[0].hiz;
    end
    @(posedge aclk);
    check(hz, 1);
    run_line(1'b1, '{red: 6'h20, green: 6'h1f, blue: 6'h3f}, 8'h78);
    check({red_col[0].level, green_col[0].level, blue_col[0].level}, 3'b101);
    check({red_col[0].code.tap, dac_enable}, 5'h0);
    $display("test single bit done");
    // power save moved away from the edge
    power_save <= 1'b1;
    cyc(3);
    check({red_col[7].hiz, blue_col[100].hiz, amp_enable}, 3'b110);
    power_save <= 1'b0;
    cyc(3);
    check({red_col[7].hiz, amp_enable}, 2'b01);
    $display("test power save done");
    axi_write(ADDR_MODE, 32'h0);
    run_line(1'b0, '{red: 6'h00, green: 6'h0f, blue: 6'h3e}, 8'h6c);
    col_chk(53, {1'b0, 4'h0, 3'h0, 4'h3, 3'h0, 4'h9, 3'h0});
    col_chk(0, {1'b0, 4'h0, 3'h0, 4'h3, 3'h0, 4'h9, 3'h0});
    $display("test short left done");
    complete_run();
  end
endmodule
